// file: hdl/sdi12_measurement_sequencer.sv
// SDI-12 measurement sequencer: powers a sensor, starts a measurement, waits
// the announced delay, fetches data and records one selected value per channel.
// Assumes a character UART on clk beside it and a recording memory that takes
// records by valid and ready.
`timescale 1ns/10ps
// What this block does
// - Only sensor addresses 0 to 9 are accepted and commands go to the configured one.
// - A channel that was never configured uses sensor address zero.
// - Sensor power comes on only for a due measurement and stays for the pre-power time.
// - Pre-power spans 0 to 63750 ms in steps of 250 ms.
// - A cycle starts with an indexed measurement command to the sensor.
// - After that delay, data requests follow until all results are in or D9 has been answered.
// - Only the result at the one-based reading index is kept.
// - Start commands offered are M0 to M5 and C0 to C4.
// - Each channel records its own stream under its own channel number.
// - The resolution sets the number of decimal places kept and scales the value by ten to that power.
module sdi12_measurement_sequencer import sdi12_seq_pkg::*; #(
   parameter int TICK_CYC = TICK_CYCLES
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Register port.
   input  wire logic [7:0] addr,
   input  wire logic [31:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic [31:0]     rd_data,
   // Character link to the UART.
   output logic            tx_valid,
   output logic [7:0]      tx_data,
   input  wire logic       tx_ready,
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_data,
   // Sensor power switch.
   output logic            power_en,
   // Records to the recording memory.
   output logic            rec_valid,
   output rec_t            rec_data,
   input  wire logic       rec_ready
);
   typedef struct packed {
      seq_st_t              st;
      logic [NCH-1:0][23:0] cfg;
      logic [NCH-1:0][31:0] res;
      logic [NCH-1:0]       pend;
      logic [NCH-1:0]       err;
      logic [1:0]           ch;
      logic [16:0]          tick;
      logic [19:0]          ms;
      logic [19:0]          dly;
      logic [3:0]           nval;
      logic [3:0]           got;
      logic [3:0]           dcmd;
      logic [3:0]           pos;
      logic [2:0]           frac;
      logic                 neg;
      logic                 actv;
      logic                 fr;
      logic                 sel_ok;
      logic [31:0]          mant;
      logic [31:0]          sel;
      logic                 power;
      logic                 txv;
      logic [7:0]           txd;
      logic [31:0]          rdd;
      logic                 recv;
   } st_t;
   st_t  s_r, s_nxt;
   logic buf_ready;

   function automatic logic is_digit(input logic [7:0] c);
      return (c >= CH_ZERO) && (c <= 8'h39);
   endfunction

   function automatic logic [3:0] digit(input logic [7:0] c);
      return c[3:0];
   endfunction

   function automatic logic [31:0] pow10(input logic [2:0] d);
      logic [31:0] p;
      p = 32'h1;
      for (int i = 0; i < 7; i++) begin
         if (i < int'(d)) p = 32'(p * 32'hA);
      end
      return p;
   endfunction

   // One character of "aX!" or "aXn!"; index zero is sent without its digit.
   function automatic logic [7:0] cmd_char(input logic [3:0] pos, input logic [3:0] adr,
                                           input logic [7:0] letter, input logic [3:0] num);
      logic [7:0] c;
      c = CH_EXCL;
      if (pos == 4'h0) c = CH_ZERO + {4'h0, adr};
      else if (pos == 4'h1) c = letter;
      else if (pos == 4'h2 && num != 4'h0) c = CH_ZERO + {4'h0, num};
      return c;
   endfunction

   // Configured fields of the running channel.
   logic [3:0]  c_adr, c_cmd, c_idx, c_num;
   logic [7:0]  c_pre, c_let;
   logic [2:0]  c_res;
   logic [19:0] pre_ms;
   always_comb begin
      c_adr  = s_r.cfg[s_r.ch][CF_ADR +: 4];
      c_cmd  = s_r.cfg[s_r.ch][CF_CMD +: 4];
      c_pre  = s_r.cfg[s_r.ch][CF_PRE +: 8];
      c_idx  = s_r.cfg[s_r.ch][CF_IDX +: 4];
      c_res  = s_r.cfg[s_r.ch][CF_RES +: 3];
      c_let  = (c_cmd < CMD_C0) ? CH_M : CH_C;
      c_num  = (c_cmd < CMD_C0) ? c_cmd : 4'(c_cmd - CMD_C0);
      pre_ms = 20'(c_pre * PRE_STEP_MS);
   end

   // Sequencer, register file and parser in one state copy.
   always_comb begin
      logic [3:0]  wch, last;
      logic [31:0] sval;
      logic        fin;
      s_nxt = s_r;
      wch   = 4'(addr[7:4] - PAGE_CH0);
      last  = 4'h0;
      sval  = 32'h0;
      fin   = 1'b0;
      // Millisecond tick from the clock; all waits count these ticks.
      s_nxt.tick = (32'(s_r.tick) >= TICK_CYC - 1) ? 17'h0 : 17'(s_r.tick + 17'h1);
      if (s_r.tick == 17'h0 && s_r.ms != 20'hFFFFF) s_nxt.ms = 20'(s_r.ms + 20'h1);
      // Selected value finishes at a sign or a line end.
      sval = 32'(s_r.mant * pow10(3'(c_res - s_r.frac)));
      if (s_r.neg) sval = 32'(-sval);
      unique case (s_r.st)
         S_IDLE: begin
            s_nxt.power = 1'b0;
            for (int i = NCH - 1; i >= 0; i--) begin
               if (s_r.pend[i]) s_nxt.ch = 2'(i);
            end
            if (s_r.pend != '0) begin
               s_nxt.pend[s_nxt.ch] = 1'b0;
               s_nxt.power = 1'b1;
               s_nxt.st    = S_PWR;
            end
         end
         S_PWR: begin
            if (s_r.ms >= pre_ms) begin
               s_nxt.st  = S_TXM;
               s_nxt.pos = 4'h0;
            end
         end
         S_TXM, S_TXD: begin
            if (s_r.st == S_TXM) begin
               last = (c_num == 4'h0) ? 4'h2 : 4'h3;
            end else begin
               last = (s_r.dcmd == 4'h0) ? 4'h2 : 4'h3;
            end
            if (!s_r.txv) begin
               s_nxt.txv = 1'b1;
               s_nxt.txd = (s_r.st == S_TXM) ?
                           cmd_char(s_r.pos, c_adr, c_let, c_num) :
                           cmd_char(s_r.pos, c_adr, CH_D, s_r.dcmd);
            end else if (tx_ready) begin
               s_nxt.txv = 1'b0;
               s_nxt.pos = 4'(s_r.pos + 4'h1);
               if (s_r.pos == last) begin
                  s_nxt.pos  = 4'h0;
                  s_nxt.st   = (s_r.st == S_TXM) ? S_ACK : S_DAT;
                  s_nxt.dly  = 20'h0;
                  s_nxt.actv = 1'b0;
                  if (s_r.st == S_TXM) s_nxt.nval = 4'h0;
               end
            end
         end
         S_ACK: begin
            // Reply "atttn": seconds in three digits, then the value count.
            if (rx_valid) begin
               if (rx_data == CH_LF) begin
                  s_nxt.dly = 20'(s_r.dly * MS_PER_S);
                  s_nxt.st  = S_MWAIT;
               end else if (is_digit(rx_data)) begin
                  s_nxt.pos = 4'(s_r.pos + 4'h1);
                  if (s_r.pos >= 4'h1 && s_r.pos <= 4'h3) begin
                     s_nxt.dly = 20'(s_r.dly * 20'hA + 20'(digit(rx_data)));
                  end else if (s_r.pos > 4'h3) begin
                     s_nxt.nval = 4'(s_r.nval * 4'hA + digit(rx_data));
                  end
               end
            end
            if (s_r.ms >= RESP_TIMEOUT_MS) fin = 1'b1;
         end
         S_MWAIT: begin
            if (s_r.ms >= s_r.dly) begin
               s_nxt.st     = S_TXD;
               s_nxt.pos    = 4'h0;
               s_nxt.dcmd   = 4'h0;
               s_nxt.got    = 4'h0;
               s_nxt.sel_ok = 1'b0;
            end
         end
         S_DAT: begin
            if (rx_valid) begin
               if (rx_data == CH_PLUS || rx_data == CH_MIN || rx_data == CH_LF) begin
                  if (s_r.actv && s_r.got == c_idx) begin
                     s_nxt.sel    = sval;
                     s_nxt.sel_ok = 1'b1;
                  end
                  s_nxt.actv = 1'b0;
               end
               if (rx_data == CH_PLUS || rx_data == CH_MIN) begin
                  s_nxt.actv = 1'b1;
                  s_nxt.neg  = (rx_data == CH_MIN);
                  s_nxt.mant = 32'h0;
                  s_nxt.frac = 3'h0;
                  s_nxt.fr   = 1'b0;
                  s_nxt.got  = 4'(s_r.got + 4'h1);
               end else if (rx_data == CH_DOT) begin
                  s_nxt.fr = 1'b1;
               end else if (is_digit(rx_data) && s_r.actv && (!s_r.fr || s_r.frac < c_res)) begin
                  // Digits past the resolution are dropped, not rounded.
                  s_nxt.mant = 32'(s_r.mant * 32'hA + 32'(digit(rx_data)));
                  if (s_r.fr) s_nxt.frac = 3'(s_r.frac + 3'h1);
               end else if (rx_data == CH_LF) begin
                  if (s_r.got >= s_r.nval || s_r.dcmd == MAX_DCMD) begin
                     s_nxt.st = S_FIN;
                  end else begin
                     s_nxt.dcmd = 4'(s_r.dcmd + 4'h1);
                     s_nxt.st   = S_TXD;
                     s_nxt.pos  = 4'h0;
                  end
               end
            end
            if (s_r.ms >= RESP_TIMEOUT_MS) fin = 1'b1;
         end
         S_FIN: begin
            if (s_r.recv) begin
               if (buf_ready) begin
                  s_nxt.recv  = 1'b0;
                  s_nxt.power = 1'b0;
                  s_nxt.st    = S_IDLE;
               end
            end else if (s_r.sel_ok) begin
               s_nxt.recv         = 1'b1;
               s_nxt.res[s_r.ch]  = s_r.sel;
               s_nxt.sel_ok       = 1'b0;
            end else begin
               fin = 1'b1;
            end
         end
      endcase
      // No reply or no selected value: drop power and mark the channel.
      if (fin) begin
         s_nxt.power = 1'b0;
         s_nxt.txv   = 1'b0;
         s_nxt.st    = S_IDLE;
      end
      if (s_nxt.st != s_r.st) s_nxt.ms = 20'h0;
      // Software writes; software clears come before hardware sets so sets win.
      if (wr_en) begin
         if (addr == OFS_CTRL) s_nxt.pend = s_nxt.pend | wr_data[NCH-1:0];
         if (addr == OFS_ERR) s_nxt.err = s_r.err & ~wr_data[NCH-1:0];
         if (addr[3:0] == OFS_CFG && addr[7:4] >= PAGE_CH0 && wch < 4'(NCH) &&
             wr_data[CF_ADR +: 4] <= MAX_ADDR &&
             wr_data[CF_CMD +: 4] <= CMD_MAX) begin
            s_nxt.cfg[wch[1:0]] = wr_data[23:0];
         end
      end
      if (fin) s_nxt.err[s_r.ch] = 1'b1;
      // Read data stands in the cycle after the strobe only.
      s_nxt.rdd = 32'h0;
      if (rd_en) begin
         if (addr == OFS_CTRL) begin
            s_nxt.rdd = {21'h0, s_r.st, (s_r.st != S_IDLE), 3'h0, s_r.pend};
         end else if (addr == OFS_ERR) begin
            s_nxt.rdd = {28'h0, s_r.err};
         end else if (addr[7:4] >= PAGE_CH0 && wch < 4'(NCH)) begin
            if (addr[3:0] == OFS_CFG) s_nxt.rdd = {8'h0, s_r.cfg[wch[1:0]]};
            if (addr[3:0] == OFS_RES) s_nxt.rdd = s_r.res[wch[1:0]];
         end
      end
   end

   // Register the whole state; reset gives every channel address zero.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r     <= '0;
         s_r.cfg <= {NCH{CFG_RST}};
      end else begin
         s_r <= s_nxt;
      end
   end

   // The buffer keeps a record while the recording memory stalls.
   rec_buffer2 u_buf (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (s_r.recv),
      .in_ready  (buf_ready),
      .in_data   ({s_r.ch, s_r.sel}),
      .out_ready (rec_ready),
      .out_valid (rec_valid),
      .out_data  (rec_data)
   );

   assign rd_data  = s_r.rdd;
   assign tx_valid = s_r.txv;
   assign tx_data  = s_r.txd;
   assign power_en = s_r.power;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_ADDR_RANGE: assert property (s_r.cfg[s_r.ch][CF_ADR +: 4] <= MAX_ADDR)
      else $error("Sensor address above nine.");
   AST_ADDR_SENT: assert property ((s_r.st == S_TXM && s_r.txv && s_r.pos == 4'h0)
      |-> tx_data == CH_ZERO + {4'h0, c_adr})
      else $error("Command sent to the wrong address.");
   AST_POWER_BUSY: assert property (power_en |-> s_r.st != S_IDLE)
      else $error("Power on while idle.");
   AST_PREPOWER: assert property ((s_r.st == S_PWR) ##1 (s_r.st == S_TXM)
      |-> $past(s_r.ms) >= $past(pre_ms))
      else $error("Pre-power cut short.");
   AST_CMD_LETTER: assert property ((s_r.st == S_TXM && s_r.txv && s_r.pos == 4'h1)
      |-> (tx_data == CH_M || tx_data == CH_C))
      else $error("Start command letter wrong.");
   AST_DATA_DELAY: assert property ((s_r.st == S_MWAIT) ##1 (s_r.st == S_TXD)
      |-> $past(s_r.ms) >= $past(s_r.dly))
      else $error("Data requested before the delay.");
   AST_PUSH_SEL: assert property ($rose(s_r.recv) |-> $past(s_r.sel_ok))
      else $error("Record pushed without a selected value.");
   AST_REC_HOLD: assert property (rec_valid && !rec_ready
      |=> rec_valid && $stable(rec_data))
      else $error("Record lost under stall.");
   AST_IDLE_OFF: assert property ((s_r.st != S_IDLE) ##1 (s_r.st == S_IDLE)
      |-> !power_en)
      else $error("Power left on after the exchange.");
   COV_RECORD: cover property (rec_valid && rec_ready);
   COV_ABANDON: cover property ($rose(s_r.err[2]));
   COV_STALL: cover property (rec_valid && !rec_ready ##1 rec_valid);
endmodule // sdi12_measurement_sequencer

// file: hdl/sdi12_seq_pkg.sv
// Package for the SDI-12 measurement sequencer: register map, field layout,
// reset values, timing constants, state encoding and the record carrier.
// Assumes a single 100 MHz clock.
package sdi12_seq_pkg;
   localparam int NCH = 4;                      // Serial channels held by the block.
   // Register map, byte offsets on an 8-bit address.
   localparam logic [7:0] OFS_CTRL = 8'h00;     // Start mask (W), pending and busy (R).
   localparam logic [7:0] OFS_ERR  = 8'h04;     // Abandoned exchanges, write one to clear.
   localparam logic [3:0] OFS_CFG  = 4'h0;      // Within a channel page: configuration.
   localparam logic [3:0] OFS_RES  = 4'h4;      // Within a channel page: last result.
   localparam logic [3:0] PAGE_CH0 = 4'h1;      // Page of channel 0, pages at 16-byte stride.
   // Configuration word fields.
   localparam int CF_ADR = 0;                   // Sensor address, 4 bits.
   localparam int CF_CMD = 4;                   // Start command, 4 bits.
   localparam int CF_PRE = 8;                   // Pre-power in steps, 8 bits.
   localparam int CF_IDX = 16;                  // One-based reading index, 4 bits.
   localparam int CF_RES = 20;                  // Resolution in decimal places, 3 bits.
   localparam logic [23:0] CFG_RST = 24'h010000; // Address 0, M0, no pre-power, index 1.
   localparam logic [3:0] MAX_ADDR = 4'h9;
   localparam logic [3:0] CMD_C0   = 4'h6;      // Codes 0..5 are M0..M5, 6..10 are C0..C4.
   localparam logic [3:0] CMD_MAX  = 4'hA;
   localparam logic [3:0] MAX_DCMD = 4'h9;      // Highest data request D9.
   // Timing.
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_MS         = 1;
   localparam int TICK_CYCLES     = TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PRE_STEP_MS     = 250;
   localparam int MS_PER_S        = 1000;
   localparam int RESP_TIMEOUT_MS = 1000;
   // Characters.
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_M    = 8'h4D;
   localparam logic [7:0] CH_C    = 8'h43;
   localparam logic [7:0] CH_D    = 8'h44;
   localparam logic [7:0] CH_EXCL = 8'h21;
   localparam logic [7:0] CH_PLUS = 8'h2B;
   localparam logic [7:0] CH_MIN  = 8'h2D;
   localparam logic [7:0] CH_DOT  = 8'h2E;
   localparam logic [7:0] CH_LF   = 8'h0A;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_PWR = 3'h1, S_TXM = 3'h3, S_ACK = 3'h2,
      S_MWAIT = 3'h6, S_TXD = 3'h7, S_DAT = 3'h5, S_FIN = 3'h4
   } seq_st_t;

   typedef struct packed {
      logic [1:0]  ch;
      logic [31:0] value;
   } rec_t;
endpackage

// file: hdl/rec_buffer2.sv
// Two-entry record buffer between the sequencer and the recording memory.
// Assumes both sides run on clk; outputs come straight from flip-flops.
`timescale 1ns/10ps
module rec_buffer2 import sdi12_seq_pkg::*; (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic arst_n,
   // Filling side.
   input  wire logic in_valid,
   output logic      in_ready,
   input  wire rec_t in_data,
   // Draining side.
   input  wire logic out_ready,
   output logic      out_valid,
   output rec_t      out_data
);
   typedef struct packed {
      logic hv;
      logic tv;
      rec_t hd;
      rec_t tl;
   } buf_t;
   buf_t s_r, s_nxt;

   // Head is what the reader sees; tail only fills while the head is stalled.
   always_comb begin
      logic push, pop;
      push  = in_valid & ~s_r.tv;
      pop   = s_r.hv & out_ready;
      s_nxt = s_r;
      if (pop) begin
         s_nxt.hv = s_r.tv;
         s_nxt.hd = s_r.tl;
         s_nxt.tv = 1'b0;
      end
      if (push) begin
         if (!s_nxt.hv) begin
            s_nxt.hv = 1'b1;
            s_nxt.hd = in_data;
         end else begin
            s_nxt.tv = 1'b1;
            s_nxt.tl = in_data;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready  = ~s_r.tv;
   assign out_valid = s_r.hv;
   assign out_data  = s_r.hd;
endmodule // rec_buffer2

// file: bench/sdi12_sensor_model.sv
// Behavioural SDI-12 sensor: takes command characters from the sequencer and
// answers with acknowledge and data lines. Assumes the bench clock and reset.
`timescale 1ns/10ps
module sdi12_sensor_model import sdi12_seq_pkg::*; #(
   parameter logic [9:0] ADDRS = 10'h009
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Character link.
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   // Power and observation.
   input  wire logic       power_en,
   output logic [31:0]     m_cmd,
   output int              d_cnt
);
   logic [31:0] sh;
   logic [7:0]  ltr;
   logic [7:0]  adr;
   logic [7:0]  q[$];
   int          gap;

   // A digit after the letter moves letter and address one place left.
   assign ltr = (sh[7:4] == 4'h3) ? sh[15:8] : sh[7:0];
   assign adr = (sh[7:4] == 4'h3) ? sh[23:16] : sh[15:8];

   // Ready toggles so the sequencer meets both prompt and stalled takes; idle
   // rx_data flips every cycle so a stale character never looks valid.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_data  <= 8'h00;
         sh       <= 32'h0;
         m_cmd    <= 32'h0;
         d_cnt    <= 0;
         q = {};
         gap = 0;
      end else begin
         tx_ready <= ~tx_ready;
         rx_valid <= 1'b0;
         rx_data  <= ~rx_data;
         // An unpowered sensor hears nothing.
         if (tx_valid && tx_ready && power_en) begin
            sh <= {sh[23:0], tx_data};
            if (tx_data == CH_EXCL) begin
               sh <= 32'h0;
               if (ltr == CH_D) d_cnt <= d_cnt + 1;
               else m_cmd <= sh;
               if (adr[7:4] == 4'h3 && adr[3:0] <= 4'h9 && ADDRS[adr[3:0]]) begin
                  gap = 4;
                  if (ltr == CH_D) q = {adr, CH_PLUS, 8'h31, CH_DOT, 8'h35, CH_MIN, 8'h32,
                     CH_DOT, 8'h32, 8'h35, CH_PLUS, 8'h33, 8'h0D, CH_LF};
                  else q = {adr, CH_ZERO, CH_ZERO, 8'h31, 8'h33, 8'h0D, CH_LF};
               end
            end
         end
         // Reply characters go out as one-cycle pulses with a gap between them.
         if (q.size() > 0) begin
            if (gap > 0) gap = gap - 1;
            else begin
               rx_valid <= 1'b1;
               rx_data  <= q.pop_front();
               gap = 1;
            end
         end
      end
   end
endmodule // sdi12_sensor_model

// file: bench/sdi12_measurement_sequencer_tb.sv
// Self-checking bench for the measurement sequencer with a sensor model.
// Assumes TICK_CYC of 10, so one millisecond lasts 10 clock cycles.
`timescale 1ns/10ps
module sdi12_measurement_sequencer_tb import sdi12_seq_pkg::*;;
   logic clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rec_ready = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wr_data = 32'h0, rd_data, m_cmd;
   logic tx_valid, tx_ready, rx_valid, power_en, rec_valid;
   logic [7:0]  tx_data, rx_data;
   rec_t        rec_data;
   int          d_cnt, n_mismatch = 0, n_tests = 0;

   sdi12_measurement_sequencer #(.TICK_CYC(10)) dut_u (.clk(clk), .arst_n(arst_n),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .power_en(power_en), .rec_valid(rec_valid), .rec_data(rec_data),
      .rec_ready(rec_ready));
   sdi12_sensor_model sensor_u (.clk(clk), .arst_n(arst_n), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .power_en(power_en), .m_cmd(m_cmd), .d_cnt(d_cnt));

   // 100 MHz clock.
   always #5 clk = ~clk;

   task automatic test_done;
      if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %0t: got %h want %h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   // Bus cycles: strobes last one cycle, read data stands in the next one.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   // Waits for power_en (0), rec_valid (1) or tx_valid (2) to reach a level.
   task automatic wait_for(input int s, input logic lvl, input int bound, output int n);
      logic [2:0] v;
      n = 0;
      v = {tx_valid, rec_valid, power_en};
      while (v[s] !== lvl) begin
         @(posedge clk);
         #1 n++;
         v = {tx_valid, rec_valid, power_en};
         if (n > bound) begin
            $display("ERROR %0t: wait ran out", $time);
            n_mismatch++;
            test_done();
         end
      end
   endtask

   task automatic t_reset;
      logic [31:0] d;
      rd(8'h10, d);
      chk(d, 32'h00010000);
      rd(8'h08, d);
      chk(d, 32'h0);
      rd(8'h00, d);
      chk(d, 32'h0);
      chk(power_en, 1'b0);
   endtask

   // Out-of-range address and command codes leave the channel unchanged.
   task automatic t_refuse;
      logic [31:0] d;
      wr(8'h20, 32'h0001000A);
      rd(8'h20, d);
      chk(d, 32'h00010000);
      wr(8'h20, 32'h000100B0);
      rd(8'h20, d);
      chk(d, 32'h00010000);
      // Address nine with the last concurrent command is the top legal pair.
      wr(8'h20, 32'h000100A9);
      rd(8'h20, d);
      chk(d, 32'h000100A9);
   endtask

   // Channel 1: sensor 3, M2, one pre-power step, second reading, two decimals.
   task automatic t_meas;
      int n;
      logic [31:0] d;
      wr(8'h20, 32'h00220123);
      wr(8'h00, 32'h2);
      wait_for(0, 1'b1, 10, n);
      // Busy in the pre-power state, start bit already taken.
      rd(8'h00, d);
      chk(d, 32'h00000180);
      wait_for(2, 1'b1, 3000, n);
      chk(n >= 2490 && n <= 2600, 1'b1);
      wait_for(1, 1'b1, 30000, n);
      chk(rec_data, {2'h1, 32'hFFFFFF1F});
      chk(m_cmd, 32'h00334D32);
      chk(d_cnt, 1);
      rd(8'h24, d);
      chk(d, 32'hFFFFFF1F);
      repeat (5) @(posedge clk);
      #1 chk(rec_valid, 1'b1);
      chk(rec_data, {2'h1, 32'hFFFFFF1F});
      @(posedge clk);
      rec_ready <= 1'b1;
      wait_for(0, 1'b0, 100, n);
   endtask

   // Channel 0 at address 0 with C0, third reading padded to one decimal.
   task automatic t_conc;
      int n;
      wr(8'h10, 32'h00130060);
      wr(8'h00, 32'h1);
      wait_for(1, 1'b1, 30000, n);
      chk(rec_data, {2'h0, 32'h0000001E});
      chk(m_cmd, 32'h00003043);
      wait_for(0, 1'b0, 100, n);
   endtask

   // Channel 2 at a silent address: the exchange is abandoned.
   task automatic t_abandon;
      int n;
      logic [31:0] d;
      wr(8'h30, 32'h00010005);
      wr(8'h00, 32'h4);
      wait_for(0, 1'b1, 10, n);
      wait_for(0, 1'b0, 20000, n);
      chk(rec_valid, 1'b0);
      rd(8'h04, d);
      chk(d, 32'h4);
      wr(8'h04, 32'h4);
      rd(8'h04, d);
      chk(d, 32'h0);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_refuse();
      t_meas();
      t_conc();
      t_abandon();
      test_done();
   end
endmodule // sdi12_measurement_sequencer_tb
